// file: hdl/lvg_pkg.sv
package lvg_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [7:0] CLK_SYNC_CTRL_OFS  = 8'h60;
    localparam logic [7:0] GFX_CTRL_OFS       = 8'h61;
    localparam logic [7:0] DEC_CTRL_OFS       = 8'h62;
    localparam logic [7:0] BR_DEC_OFS         = 8'h63;
    localparam logic [7:0] STAT_RD_OFS        = 8'h64;
    localparam logic [7:0] CLK_SYNC_CTRL_RST  = 8'h00;
    localparam logic [7:0] GFX_CTRL_RST       = 8'h08;
    localparam logic [7:0] DEC_CTRL_RST       = 8'h00;

    // ************************************************************
    // Clock control field positions.
    // ************************************************************
    localparam int GMCLK_GATE_BIT = 0;
    localparam int PLL_RESYNC_BIT = 1;
    localparam int PROP_GFX_BIT   = 2;
    localparam int GFX_RELEASE_BIT = 3;
    localparam int DLL_GATE_BIT   = 4;

    // ************************************************************
    // Graphics control field positions (offset 61).
    // ************************************************************
    localparam int VGA_OFF_BIT    = 1;
    localparam int GFX_OFF_BIT    = 3;

    // ************************************************************
    // Decode control field positions (offsets 62 and 63).
    // ************************************************************
    localparam int GFX_MEM_EN_BIT = 0;
    localparam int GFX_IO_EN_BIT  = 1;
    localparam int GFX_D0_BIT     = 2;
    localparam int MISC_MEM_BIT   = 3;
    localparam int MISC_IO_BIT    = 4;
    localparam int MAP_LSB        = 5;
    localparam int BR_MEM_EN_BIT  = 0;
    localparam int BR_IO_EN_BIT   = 1;
    localparam int FWD_EN_BIT     = 2;
    localparam int MONO_BIT       = 3;
    localparam int ISA_EN_BIT     = 4;

    // ************************************************************
    // Sub-class codes and targets.
    // ************************************************************
    localparam logic [7:0] SUBCLASS_VGA   = 8'h00;
    localparam logic [7:0] SUBCLASS_OTHER = 8'h80;
    localparam logic [2:0] TGT_GFX = 3'h1;
    localparam logic [2:0] TGT_BRG = 3'h2;
    localparam logic [2:0] TGT_HUB = 3'h4;

endpackage : lvg_pkg

// file: hdl/lvg_router.sv
// Operation
// - Graphics unit wins a VGA cycle, then bridge, then hub port.
// - Graphics memory decode needs enable, no claim-off, mem-en, D0, misc bit.
// - Memory map field picks graphics ranges: 00 all, 01 A, 10 B0, 11 B8.
// - Bridge memory decode: forward 0 hub, 1 bridge, with mono split.
// - Cycle not claimed by graphics or bridge goes to hub port.
// - Graphics I/O decode needs enable, no claim-off, io-en, D0.
// - Misc I/O bit 0 claims 3Cx, 3B0-3BB; bit 1 claims 3Cx, 3Dx.
// - Bridge I/O decode needs io-en; covers VGA and mono ports.
// - Forward 0 mono 0: hub, except 3BC-3BF to bridge without ISA.
// - Forward 1: VGA to bridge; with mono, 3BF also to bridge; 3BC-3BE to hub.
// - SMM segment sits at top, graphics memory directly below it.
// - Bit 4 gates memory clocks from DLL outputs cleanly.
// - Bit 0 gates graphics and memory clocks cleanly for reprogramming.
// - Bit 1 set resets dividers and loads frequency settings.
// - Bit 1 cleared after set resynchronises clocks to processor clock.
// - Bit 2 set propagates graphics select; bridge hides, graphics appears.
// - Writing 0 to bit 2 does nothing; software clears it soon.
// - Bit 3 releases graphics reset; only hardware reset re-asserts it. Code acts on bit 3 only after bit 2 propagates graphics on.
// - Claim-off stops all graphics VGA claims, sub-class reads 80h.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lvg_router
    import lvg_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Register port.
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // Host cycle to be routed.
    input  wire logic        i_cyc_valid,
    input  wire logic        i_cyc_is_io,
    input  wire logic [19:0] i_cyc_addr,
    output logic      [2:0]  o_cyc_target,
    // Memory carve-out.
    input  wire logic [31:0] i_top_of_mem,
    input  wire logic [31:0] i_smm_size,
    input  wire logic [31:0] i_gfx_mem_size,
    output logic      [31:0] o_smm_base,
    output logic      [31:0] o_gfx_mem_base,
    // Clock and reset controls.
    output logic             o_dll_clk_en,
    output logic             o_gfx_mem_clk_en,
    output logic             o_div_reset,
    output logic             o_freq_load,
    output logic             o_pll_resync,
    output logic             o_gfx_clk_en,
    output logic             o_bridge_cfg_vis,
    output logic             o_gfx_cfg_vis,
    output logic             o_gfx_rst_n,
    output logic      [7:0]  o_gfx_subclass
);

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [7:0] clk_ctrl_ff;
    logic [7:0] gfx_ctrl_ff;
    logic [7:0] dec_gfx_ff;
    logic [7:0] dec_br_ff;
    logic       gfx_on_ff;
    logic       rel_ff;
    logic       resync_ff;
    logic [7:0] rdata_ff;
    logic [2:0] tgt_ff;
    logic [31:0] smm_ff;
    logic [31:0] gfxb_ff;

    // Write decode.
    wire wr_clk = i_reg_wr && (i_reg_addr == CLK_SYNC_CTRL_OFS);
    wire wr_gfx = i_reg_wr && (i_reg_addr == GFX_CTRL_OFS);
    wire wr_dgf = i_reg_wr && (i_reg_addr == DEC_CTRL_OFS);
    wire wr_dbr = i_reg_wr && (i_reg_addr == BR_DEC_OFS);

    // Writing 1 to bit 2 propagates the pending graphics select.
    wire prop_pulse = wr_clk && i_reg_wdata[PROP_GFX_BIT];
    // Release acts only once graphics has been propagated on.
    wire rel_pulse  = wr_clk && i_reg_wdata[GFX_RELEASE_BIT]
                    && gfx_on_ff;
    // Falling edge of the resync bit by software write.
    wire resync_pulse = wr_clk && clk_ctrl_ff[PLL_RESYNC_BIT]
                      && !i_reg_wdata[PLL_RESYNC_BIT];

    // Control register; reserved bits stay zero. Bit 2 is held but its
    // 0 write has no other side effect.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_ctrl_ff <= CLK_SYNC_CTRL_RST;
        end else if (wr_clk) begin
            clk_ctrl_ff <= {3'h0, i_reg_wdata[4:0]};
        end
    end

    // Graphics and decode configuration registers.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gfx_ctrl_ff <= GFX_CTRL_RST;
            dec_gfx_ff  <= DEC_CTRL_RST;
            dec_br_ff   <= DEC_CTRL_RST;
        end else begin
            if (wr_gfx) gfx_ctrl_ff <= i_reg_wdata;
            if (wr_dgf) dec_gfx_ff  <= i_reg_wdata;
            if (wr_dbr) dec_br_ff   <= i_reg_wdata;
        end
    end

    // Propagated graphics enable follows the select only on bit 2 write.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gfx_on_ff <= 1'b0;
        end else if (prop_pulse) begin
            gfx_on_ff <= !gfx_ctrl_ff[GFX_OFF_BIT];
        end
    end

    // Reset release is sticky until hardware reset.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rel_ff <= 1'b0;
        end else if (rel_pulse) begin
            rel_ff <= 1'b1;
        end
    end

    // One-cycle resync strobe to the PLL.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            resync_ff <= 1'b0;
        end else begin
            resync_ff <= resync_pulse;
        end
    end

    // ************************************************************
    // Decode qualification.
    // ************************************************************
    wire vga_off  = gfx_ctrl_ff[VGA_OFF_BIT];
    wire gfx_base = gfx_on_ff && !vga_off && dec_gfx_ff[GFX_D0_BIT];
    wire gfx_memq = gfx_base && dec_gfx_ff[GFX_MEM_EN_BIT]
                  && dec_gfx_ff[MISC_MEM_BIT];
    wire gfx_ioq  = gfx_base && dec_gfx_ff[GFX_IO_EN_BIT];
    wire [1:0] map_sel = dec_gfx_ff[MAP_LSB +: 2];
    wire fwd  = dec_br_ff[FWD_EN_BIT];
    wire mono = dec_br_ff[MONO_BIT];

    // Memory range hits.
    wire m_a0 = i_cyc_addr[19:16] == 4'hA;
    wire m_b0 = i_cyc_addr[19:15] == 5'h16;
    wire m_b8 = i_cyc_addr[19:15] == 5'h17;
    wire m_vga = m_a0 || m_b0 || m_b8;

    // Graphics memory claim by map field.
    wire gm_hit = gfx_memq && m_vga && ((map_sel == 2'h0)
                || (map_sel == 2'h1 && m_a0)
                || (map_sel == 2'h2 && m_b0)
                || (map_sel == 2'h3 && m_b8));

    // Bridge memory claim; the mono split sends the mono range to hub.
    wire bm_hit = dec_br_ff[BR_MEM_EN_BIT] && m_vga && fwd
                && !(mono && m_b0);

    // I/O range hits on the low ten address bits.
    wire [9:0] ioa = i_cyc_addr[9:0];
    wire io_3cx = ioa[9:4] == 6'h3C;
    wire io_3dx = ioa[9:4] == 6'h3D;
    wire io_3b0 = (ioa >= 10'h3B0) && (ioa <= 10'h3BB);
    wire io_3bc = (ioa >= 10'h3BC) && (ioa <= 10'h3BF);
    wire io_mda = (ioa == 10'h3B4) || (ioa == 10'h3B5)
                || (ioa == 10'h3B8) || (ioa == 10'h3B9)
                || (ioa == 10'h3BA) || (ioa == 10'h3BF);
    wire io_vga = io_3b0 || io_3cx || io_3dx;

    // Graphics I/O claim selected by the misc-output I/O bit.
    wire gi_hit = gfx_ioq && (io_3cx || (dec_gfx_ff[MISC_IO_BIT]
                ? io_3dx : io_3b0));

    // Bridge I/O claim; with forward and mono the bridge also claims 3BF,
    // while 3BC-3BE are not claimed by the bridge and go to the hub alone.
    wire br_io = dec_br_ff[BR_IO_EN_BIT];
    wire bi_hit = br_io && ((!fwd && !mono && io_3bc
                && !dec_br_ff[ISA_EN_BIT])
                || (fwd && io_vga)
                || (fwd && mono && io_mda));

    // Priority select: graphics, bridge, hub.
    wire [2:0] nxt_tgt = !i_cyc_valid ? 3'h0
        : (i_cyc_is_io ? gi_hit : gm_hit) ? TGT_GFX
        : (i_cyc_is_io ? bi_hit : bm_hit) ? TGT_BRG
        : TGT_HUB;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tgt_ff <= 3'h0;
        end else begin
            tgt_ff <= nxt_tgt;
        end
    end

    // ************************************************************
    // Memory carve-out: SMM on top, graphics below it.
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            smm_ff  <= 32'h0;
            gfxb_ff <= 32'h0;
        end else begin
            smm_ff  <= i_top_of_mem - i_smm_size;
            gfxb_ff <= i_top_of_mem - i_smm_size - i_gfx_mem_size;
        end
    end

    // ************************************************************
    // Register read port.
    // ************************************************************
    wire [7:0] stat = {4'h0, resync_ff, rel_ff, gfx_on_ff, vga_off};
    wire [7:0] rd_mux = (i_reg_addr == CLK_SYNC_CTRL_OFS) ? clk_ctrl_ff
        : (i_reg_addr == GFX_CTRL_OFS) ? gfx_ctrl_ff
        : (i_reg_addr == DEC_CTRL_OFS) ? dec_gfx_ff
        : (i_reg_addr == BR_DEC_OFS) ? dec_br_ff
        : (i_reg_addr == STAT_RD_OFS) ? stat : 8'h00;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= i_reg_rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    // Gates come straight from flip-flops so the enables never glitch.
    assign o_dll_clk_en     = !clk_ctrl_ff[DLL_GATE_BIT];
    assign o_gfx_mem_clk_en = !clk_ctrl_ff[GMCLK_GATE_BIT];
    assign o_div_reset      = clk_ctrl_ff[PLL_RESYNC_BIT];
    assign o_freq_load      = clk_ctrl_ff[PLL_RESYNC_BIT];
    assign o_pll_resync     = resync_ff;
    assign o_gfx_clk_en     = gfx_on_ff;
    assign o_bridge_cfg_vis = !gfx_on_ff;
    assign o_gfx_cfg_vis    = gfx_on_ff;
    assign o_gfx_rst_n      = rel_ff;
    assign o_gfx_subclass   = vga_off ? SUBCLASS_OTHER
                                      : SUBCLASS_VGA;
    assign o_reg_rdata      = rdata_ff;
    assign o_cyc_target     = tgt_ff;
    assign o_smm_base       = smm_ff;
    assign o_gfx_mem_base   = gfxb_ff;

    // ************************************************************
    // Checks.
    // ************************************************************
    property p_prio;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && !i_cyc_is_io && gm_hit) |=> o_cyc_target == TGT_GFX;
    endproperty
    a_prio: assert property (p_prio) else $error("gfx not first");

    property p_claimoff;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && vga_off) |=> o_cyc_target != TGT_GFX;
    endproperty
    a_claimoff: assert property (p_claimoff)
        else $error("claim while off");

    property p_default;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && !gfx_base && !dec_br_ff[BR_MEM_EN_BIT]
         && !br_io) |=> o_cyc_target == TGT_HUB;
    endproperty
    a_default: assert property (p_default) else $error("no hub");

    property p_resync;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $fell(clk_ctrl_ff[PLL_RESYNC_BIT]) |-> o_pll_resync;
    endproperty
    a_resync: assert property (p_resync) else $error("no resync");

    property p_release;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_gfx_rst_n |=> o_gfx_rst_n;
    endproperty
    a_release: assert property (p_release) else $error("rst back");

    property p_prop;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (prop_pulse && !gfx_ctrl_ff[GFX_OFF_BIT]) |=> o_gfx_cfg_vis
            && !o_bridge_cfg_vis;
    endproperty
    a_prop: assert property (p_prop) else $error("no propagate");

    property p_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_clk && i_reg_wdata[GMCLK_GATE_BIT]) |=> !o_gfx_mem_clk_en;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_dll;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_clk && i_reg_wdata[DLL_GATE_BIT]) |=> !o_dll_clk_en;
    endproperty
    a_dll: assert property (p_dll) else $error("dll not gated");

    // Gating checks: an unqualified decode must never reach the graphics
    // unit, since a stray claim would hide the cycle from the bridge.
    property p_memq;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && !i_cyc_is_io && !gfx_memq)
            |=> o_cyc_target != TGT_GFX;
    endproperty
    a_memq: assert property (p_memq) else $error("mem claim unqualified");

    property p_ioq;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && i_cyc_is_io && !gfx_ioq)
            |=> o_cyc_target != TGT_GFX;
    endproperty
    a_ioq: assert property (p_ioq) else $error("io claim unqualified");

    property p_fwd0;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_cyc_valid && !i_cyc_is_io && !gm_hit && !fwd)
            |=> o_cyc_target == TGT_HUB;
    endproperty
    a_fwd0: assert property (p_fwd0) else $error("fwd off not hub");

    property p_div;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_clk && i_reg_wdata[PLL_RESYNC_BIT]) |=> o_div_reset && o_freq_load;
    endproperty
    a_div: assert property (p_div) else $error("dividers not reset");

    property p_prop_zero;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_clk && !i_reg_wdata[PROP_GFX_BIT])
            |=> $stable(o_gfx_cfg_vis) && $stable(o_gfx_clk_en);
    endproperty
    a_prop_zero: assert property (p_prop_zero) else $error("zero acted");

    property p_rel_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!gfx_on_ff && !o_gfx_rst_n) |=> !o_gfx_rst_n;
    endproperty
    a_rel_gate: assert property (p_rel_gate) else $error("early release");

    property p_carve;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_smm_base == $past(i_top_of_mem) - $past(i_smm_size))
            && (o_gfx_mem_base == o_smm_base - $past(i_gfx_mem_size));
    endproperty
    a_carve: assert property (p_carve) else $error("bad carve-out");

endmodule : lvg_router
`default_nettype wire

// file: verification/lvg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Host processor model.
// ********************
module lvg_host_model (
    // Cycle toward the router.
    output logic        o_cyc_valid,
    output logic        o_cyc_is_io,
    output logic [19:0] o_cyc_addr
);
    // Bus idles at power-up.
    initial begin
        o_cyc_valid = 1'b0;
        o_cyc_is_io = 1'b0;
        o_cyc_addr  = 20'h00000;
    end

    // Called just after a rising edge; one cycle per call.
    // An idle bus shows the inverse address so stale values never match.
    task automatic issue(input logic v, input logic io, input logic [19:0] a);
        o_cyc_valid <= v;
        o_cyc_is_io <= io;
        o_cyc_addr  <= v ? a : ~o_cyc_addr;
    endtask : issue
endmodule : lvg_host_model
`default_nettype wire

// file: verification/lvg_router_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lvg_router_tb_top;
    import lvg_pkg::*;
    // ********************
    // Signals.
    // ********************
    logic        i_core_clk, i_rst_n, i_reg_wr, i_reg_rd;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_gfx_subclass;
    logic        i_cyc_valid, i_cyc_is_io;
    logic [19:0] i_cyc_addr, a;
    logic [2:0]  o_cyc_target, pe;
    logic [31:0] i_top_of_mem, i_smm_size, i_gfx_mem_size;
    logic [31:0] o_smm_base, o_gfx_mem_base, ps, pg;
    logic        o_dll_clk_en, o_gfx_mem_clk_en, o_div_reset, o_freq_load;
    logic        o_pll_resync, o_gfx_clk_en, o_bridge_cfg_vis;
    logic        o_gfx_cfg_vis, o_gfx_rst_n, v, io;
    logic [7:0]  gc, dc, bc;
    logic [9:0]  p;
    int          err_count = 0, compares = 0;

    lvg_router u_dut (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_cyc_valid, .i_cyc_is_io,
        .i_cyc_addr, .o_cyc_target, .i_top_of_mem, .i_smm_size,
        .i_gfx_mem_size, .o_smm_base, .o_gfx_mem_base, .o_dll_clk_en,
        .o_gfx_mem_clk_en, .o_div_reset, .o_freq_load, .o_pll_resync,
        .o_gfx_clk_en, .o_bridge_cfg_vis, .o_gfx_cfg_vis, .o_gfx_rst_n,
        .o_gfx_subclass);
    lvg_host_model u_host (.o_cyc_valid(i_cyc_valid),
        .o_cyc_is_io(i_cyc_is_io), .o_cyc_addr(i_cyc_addr));

    // ********************
    // Helpers.
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Bus cycles; each returns at the falling edge after the strobe.
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge i_core_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= ad;
        i_reg_wdata <= wd;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
        @(negedge i_core_clk);
    endtask : wr

    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= ad;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_core_clk);
        chk(o_reg_rdata, exp);
    endtask : rchk

    // Expected target of one host cycle under a given setup.
    function automatic logic [2:0] exp_tgt(input logic io,
        input logic [19:0] ad, input logic [7:0] g, input logic [7:0] m,
        input logic [7:0] b);
        logic [1:0] r;
        logic [9:0] q;
        logic       vga;
        q = ad[9:0];
        r = (ad[19:16] == 4'hA) ? 2'd0 : (ad[15] ? 2'd2 : 2'd1);
        vga = (q <= 10'h3BB) || (q >= 10'h3C0);
        if (!io) begin
            if (!g[1] && m[0] && m[2] && m[3] &&
                (m[6:5] == 2'd0 || m[6:5] == r + 2'd1)) return TGT_GFX;
            if (!b[0] || !b[2]) return TGT_HUB;
            return (b[3] && r == 2'd1) ? TGT_HUB : TGT_BRG;
        end
        if (!g[1] && m[1] && m[2] && (q[9:4] == 6'h3C ||
            (m[4] ? q[9:4] == 6'h3D : q <= 10'h3BB))) return TGT_GFX;
        if (!b[1]) return TGT_HUB;
        if (!b[2]) return (!vga && !b[4]) ? TGT_BRG : TGT_HUB;
        return (vga || (b[3] && q == 10'h3BF)) ? TGT_BRG : TGT_HUB;
    endfunction : exp_tgt

    // ********************
    // Clock, watchdog and sequence.
    // ********************
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // A hang is cut short here and counted.
    initial begin
        repeat (60000) @(posedge i_core_clk);
        err_count++;
        end_sim();
    end

    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
        {i_top_of_mem, i_smm_size, i_gfx_mem_size, ps, pg, pe} = '0;
        void'($urandom(86490));
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(negedge i_core_clk);
        chk({o_dll_clk_en, o_gfx_mem_clk_en, o_gfx_rst_n, o_bridge_cfg_vis,
             o_gfx_cfg_vis, o_gfx_clk_en}, 6'b110100);
        rchk(CLK_SYNC_CTRL_OFS, CLK_SYNC_CTRL_RST);
        rchk(GFX_CTRL_OFS, GFX_CTRL_RST);
        rchk(8'h7F, 8'h00);
        // Gate bits first, then the divider resync bit.
        wr(CLK_SYNC_CTRL_OFS, 8'h11);
        chk({o_dll_clk_en, o_gfx_mem_clk_en}, 2'b00);
        wr(CLK_SYNC_CTRL_OFS, 8'hF3);
        chk({o_div_reset, o_freq_load}, 2'b11);
        rchk(CLK_SYNC_CTRL_OFS, 8'h13);
        wr(CLK_SYNC_CTRL_OFS, 8'h10);
        chk({o_pll_resync, o_dll_clk_en, o_gfx_mem_clk_en}, 3'b101);
        @(negedge i_core_clk);
        chk(o_pll_resync, 1'b0);
        wr(CLK_SYNC_CTRL_OFS, 8'h08);
        chk({o_dll_clk_en, o_gfx_rst_n}, 2'b10);
        wr(GFX_CTRL_OFS, 8'h00);
        wr(CLK_SYNC_CTRL_OFS, 8'h04);
        chk({o_gfx_clk_en, o_gfx_cfg_vis, o_bridge_cfg_vis}, 3'b110);
        wr(CLK_SYNC_CTRL_OFS, 8'h00);
        chk({o_gfx_clk_en, o_gfx_cfg_vis, o_bridge_cfg_vis}, 3'b110);
        wr(CLK_SYNC_CTRL_OFS, 8'h08);
        wr(CLK_SYNC_CTRL_OFS, 8'h00);
        chk(o_gfx_rst_n, 1'b1);
        rchk(STAT_RD_OFS, 8'h06);
        for (int i = 0; i < 40; i++) begin
            gc = ($urandom % 4 == 0) ? 8'h02 : 8'h00;
            dc = 8'($urandom) & 8'h7F;
            if ($urandom % 2) dc[3:0] = 4'hF;
            bc = 8'($urandom) & 8'h1F;
            if (!bc[2]) bc[3] = 1'b0;
            if (i == 0) {gc, dc, bc} = {8'h00, 8'h0F, 8'h03};
            wr(GFX_CTRL_OFS, gc);
            wr(DEC_CTRL_OFS, dc);
            wr(BR_DEC_OFS, bc);
            chk(o_gfx_subclass, gc[1] ? SUBCLASS_OTHER : SUBCLASS_VGA);
            rchk(DEC_CTRL_OFS, dc);
            rchk(BR_DEC_OFS, bc);
            // Back-to-back cycles; each result is checked one cycle on.
            for (int j = 0; j < 9; j++) begin
                @(posedge i_core_clk);
                v = (j < 8) && ($urandom % 8 != 0);
                io = 1'($urandom % 2);
                a = 20'hA0000 + 20'($urandom % 32'h20000);
                p = 10'h3B0 + 10'($urandom % 48);
                if (bc[3] && p >= 10'h3BC && p <= 10'h3BE) p = 10'h3BF;
                if (io) a = {10'h000, p};
                if (i == 0 && j < 2) {v, io, a} = {1'b1, j[0], j[0] ?
                    20'h003BC : 20'hA0000};
                u_host.issue(v, io, a);
                i_top_of_mem   <= (i == 0) ? 32'h04000000 : 32'h08000000 + $urandom % 32'h01000000;
                i_smm_size     <= (i == 0) ? 32'h00080000 : $urandom % 32'h00100000;
                i_gfx_mem_size <= (i == 0) ? 32'h00100000 : $urandom % 32'h01000000;
                @(negedge i_core_clk);
                chk(o_cyc_target, pe);
                chk(o_smm_base, ps);
                chk(o_gfx_mem_base, pg);
                pe = v ? exp_tgt(io, a, gc, dc, bc) : 3'b000;
                ps = i_top_of_mem - i_smm_size;
                pg = ps - i_gfx_mem_size;
            end
        end
        // Only a hardware reset puts graphics back into reset.
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        @(negedge i_core_clk);
        chk({o_gfx_rst_n, o_cyc_target}, 4'b0000);
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rchk(CLK_SYNC_CTRL_OFS, CLK_SYNC_CTRL_RST);
        end_sim();
    end
endmodule : lvg_router_tb_top
`default_nettype wire
